// File: rtl/rlc_pkg.sv
// Purpose: constants and types for the record level control loop
// Assumes: 20 MHz system clock, 16-bit signed converter samples
// Notes: level units are 1.5 dB steps, 64 units equal full scale
package rlc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 9;
  localparam int SAMPLE_W = 16;
  localparam int GAIN_W = 6;
  localparam int LVL_W = 7;
  localparam int CNT_W = 32;
  // register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_LEFT_GAIN = 8'h00;
  localparam logic [ADDR_W-1:0] IDX_RIGHT_GAIN = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_CTRL_A = 8'h11;
  localparam logic [ADDR_W-1:0] IDX_CTRL_B = 8'h12;
  localparam logic [ADDR_W-1:0] IDX_RAMP = 8'h13;
  localparam logic [ADDR_W-1:0] IDX_GATE = 8'h14;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h18;
  // reset values
  localparam logic [REG_W-1:0] CTRL_A_RST = 9'h07b;
  localparam logic [REG_W-1:0] CTRL_B_RST = 9'h000;
  localparam logic [REG_W-1:0] RAMP_RST = 9'h032;
  localparam logic [REG_W-1:0] GATE_RST = 9'h000;
  localparam logic [REG_W-1:0] SW_GAIN_RST = 9'h097;
  // field positions
  localparam int LOOP_EN_BIT = 8;
  localparam int STEREO_BIT = 7;
  localparam int CEIL_LSB = 4;
  localparam int TARGET_LSB = 0;
  localparam int LOOP_ZC_BIT = 7;
  localparam int HOLD_LSB = 0;
  localparam int DECAY_LSB = 4;
  localparam int ATTACK_LSB = 0;
  localparam int THR_LSB = 3;
  localparam int ACT_LSB = 1;
  localparam int GATE_EN_BIT = 0;
  localparam int SW_GAIN_LSB = 0;
  localparam int SW_ZC_BIT = 6;
  localparam int SW_SIL_BIT = 7;
  localparam int SW_UPD_BIT = 8;
  // gain and level scales
  localparam logic [GAIN_W-1:0] GAIN_ZERO_DB = 6'h17;
  localparam int CEIL_BASE = 7;
  localparam int CEIL_STEP = 8;
  localparam int TARGET_BASE = 45;
  localparam int GATE_BASE = 13;
  localparam logic [SAMPLE_W-1:0] LIMIT_MAG = 16'h7000;
  localparam int BOOST_13DB = 9;
  localparam int BOOST_20DB = 13;
  localparam int BOOST_29DB = 19;
  localparam logic [1:0] GATE_MUTE = 2'h1;
  localparam logic [3:0] MAX_SHIFT = 4'ha;
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RAMP_STEPS = 57;
  localparam int ATTACK_BASE_NS = 6000000;
  localparam int DECAY_BASE_NS = 24000000;
  localparam int HOLD_BASE_NS = 2670000;
  localparam int ATTACK_STEP_CYC = ATTACK_BASE_NS / CLK_PERIOD_NS / RAMP_STEPS;
  localparam int DECAY_STEP_CYC = DECAY_BASE_NS / CLK_PERIOD_NS / RAMP_STEPS;
  localparam int HOLD_BASE_CYC = HOLD_BASE_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    RLC_OFF = 2'b00,
    RLC_DOWN = 2'b01,
    RLC_HOLD = 2'b10,
    RLC_UP = 2'b11
  } rlc_state_t;
endpackage : rlc_pkg

// File: rtl/rlc_top.sv
// Purpose: automatic record level loop with limiter and noise gate
// Assumes: samples arrive with adc_valid; Avalon-MM slave registers
// Notes: bit 7 of control a widens the loop to both channels
//
// What this block does
// RULE1: loop ignores software gain, update, zero-cross, silence
// RULE2: peak detection steers amplifier gain to target
// RULE3: enable bit 8: off, or left only
// RULE4: target -28.5 to -6 dBFS, reset 1011
// RULE5: gain ceiling +30 dB down 6 dB steps
// RULE6: hold delay before raising, doubling per code
// RULE7: reduce gain at once when above target
// RULE8: decay ramp 24 ms doubling, capped code 1010
// RULE9: attack ramp 6 ms doubling, capped, reset 0010
// RULE10: stereo uses larger peak, same gain both
// RULE11: single channel loop leaves other channel software
// RULE12: unused or dc channels excluded from detector
// RULE13: works on digitally mixed mono samples
// RULE14: bit 7 routes loop changes through zero-cross
// RULE15: limiter above 87.5% uses fastest attack
// RULE16: gate when level below threshold+gain+boost
// RULE17: gate threshold 1.5 dB steps, 11111 -30 dBFS
// RULE18: gate action freezes gain or mutes output
// RULE19: gate enable bit 0, reset off
// RULE20: gate only with loop, same channels
// RULE21: software equalises input gains before enabling
// RULE22: gain +30 to -17.25 dB, 0.75 dB steps
// RULE23: gain steps one increment per derived interval
`timescale 1ns/100ps
`default_nettype none
module rlc_top #(
  parameter int DECAY_STEP_CYC = rlc_pkg::DECAY_STEP_CYC,
  parameter int HOLD_BASE_CYC = rlc_pkg::HOLD_BASE_CYC
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [rlc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [rlc_pkg::DATA_W-1:0] avs_writedata,
  output logic [rlc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [rlc_pkg::SAMPLE_W-1:0] adc_left,
  input wire logic signed [rlc_pkg::SAMPLE_W-1:0] adc_right,
  input wire logic adc_valid,
  input wire logic left_excluded,
  input wire logic right_excluded,
  input wire logic [1:0] boost_code,
  output logic [rlc_pkg::GAIN_W-1:0] left_input_gain,
  output logic [rlc_pkg::GAIN_W-1:0] right_input_gain,
  output logic left_zero_cross_enable,
  output logic right_zero_cross_enable,
  output logic left_input_silence,
  output logic right_input_silence,
  output logic adc_left_mute,
  output logic adc_right_mute
);
  localparam logic [rlc_pkg::CNT_W-1:0] ATK_BASE =
    rlc_pkg::CNT_W'(rlc_pkg::ATTACK_STEP_CYC);
  localparam logic [rlc_pkg::CNT_W-1:0] DCY_BASE =
    rlc_pkg::CNT_W'(DECAY_STEP_CYC);
  localparam logic [rlc_pkg::CNT_W-1:0] HLD_BASE =
    rlc_pkg::CNT_W'(HOLD_BASE_CYC);

  logic [rlc_pkg::REG_W-1:0] ctrl_a_q, ctrl_b_q, ramp_q, gate_q;
  logic [rlc_pkg::REG_W-1:0] sw_left_q, sw_right_q;
  logic [rlc_pkg::GAIN_W-1:0] left_applied_q, right_applied_q;
  logic [rlc_pkg::GAIN_W-1:0] loop_gain_q;
  logic [rlc_pkg::GAIN_W-1:0] left_gain_q, right_gain_q;
  logic left_zc_q, right_zc_q, left_sil_q, right_sil_q;
  logic left_mute_q, right_mute_q;
  logic [rlc_pkg::DATA_W-1:0] rdata_q;
  logic wait_q;
  logic [rlc_pkg::CNT_W-1:0] cnt_q;
  rlc_pkg::rlc_state_t state_q;
  logic above_q, below_q, limit_q, gate_on_q;

  // absolute value; -32768 maps to 0x8000, still the largest magnitude
  function automatic logic [rlc_pkg::SAMPLE_W-1:0] mag_of(
    input logic signed [rlc_pkg::SAMPLE_W-1:0] x);
    mag_of = x[rlc_pkg::SAMPLE_W-1] ? rlc_pkg::SAMPLE_W'(-x)
                                    : rlc_pkg::SAMPLE_W'(x);
  endfunction : mag_of

  // coarse log: four units per octave from the leading one and two bits
  function automatic logic [rlc_pkg::LVL_W-1:0] lvl_units(
    input logic [rlc_pkg::SAMPLE_W-1:0] m);
    logic [rlc_pkg::LVL_W-1:0] u;
    u = '0;
    for (int i = 2; i < rlc_pkg::SAMPLE_W; i++) begin
      if (m[i]) begin
        u = rlc_pkg::LVL_W'(4 * i) + rlc_pkg::LVL_W'(m[i-1 -: 2]);
      end
    end
    if (u == '0) begin
      u = rlc_pkg::LVL_W'(m[1:0]);
    end
    lvl_units = u;
  endfunction : lvl_units

  function automatic logic [rlc_pkg::CNT_W-1:0] ramp_cycles(
    input logic [rlc_pkg::CNT_W-1:0] base, input logic [3:0] code);
    logic [3:0] sh;
    sh = (code > rlc_pkg::MAX_SHIFT) ? rlc_pkg::MAX_SHIFT : code;
    ramp_cycles = base << sh;
  endfunction : ramp_cycles

  logic write_ok, read_ok, word_ok;
  logic [rlc_pkg::ADDR_W-1:0] idx;
  logic loop_on, stereo, freeze;
  logic [3:0] hold_code;
  logic [rlc_pkg::GAIN_W-1:0] ceiling;
  logic [rlc_pkg::SAMPLE_W-1:0] lmag, rmag, peak;
  logic [rlc_pkg::CNT_W-1:0] down_cyc, up_cyc, hold_cyc;
  int level, gate_ref, boost_units;

  assign word_ok = (avs_address[1:0] == 2'h0);
  assign idx = {2'h0, avs_address[rlc_pkg::ADDR_W-1:2]};
  assign write_ok = avs_write && !wait_q && word_ok;
  assign read_ok = avs_read && wait_q;
  assign loop_on = ctrl_a_q[rlc_pkg::LOOP_EN_BIT]; // RULE3
  assign stereo = loop_on && ctrl_a_q[rlc_pkg::STEREO_BIT];
  assign hold_code = ctrl_b_q[rlc_pkg::HOLD_LSB +: 4];
  assign ceiling = rlc_pkg::GAIN_W'(rlc_pkg::CEIL_BASE + rlc_pkg::CEIL_STEP
    * int'(ctrl_a_q[rlc_pkg::CEIL_LSB +: 3])); // RULE5 RULE22
  assign freeze = gate_on_q && !gate_q[rlc_pkg::ACT_LSB]; // RULE18


  // detector input: only channels under loop control and in use
  always_comb begin
    lmag = (loop_on && !left_excluded) ? mag_of(adc_left) : '0; // RULE12
    rmag = (stereo && !right_excluded) ? mag_of(adc_right) : '0; // RULE12
    peak = (lmag > rmag) ? lmag : rmag; // RULE10 RULE13
    level = int'(lvl_units(peak));
    unique case (boost_code)
      2'h0: boost_units = 0;
      2'h1: boost_units = rlc_pkg::BOOST_13DB;
      2'h2: boost_units = rlc_pkg::BOOST_20DB;
      2'h3: boost_units = rlc_pkg::BOOST_29DB;
    endcase
    gate_ref = rlc_pkg::GATE_BASE + int'(gate_q[rlc_pkg::THR_LSB +: 5])
      + (int'(loop_gain_q) - int'(rlc_pkg::GAIN_ZERO_DB)) / 2
      + boost_units; // RULE16 RULE17
    down_cyc = limit_q ? ATK_BASE
      : ramp_cycles(ATK_BASE, ramp_q[rlc_pkg::ATTACK_LSB +: 4]); // RULE9
    up_cyc = ramp_cycles(DCY_BASE, ramp_q[rlc_pkg::DECAY_LSB +: 4]); // RULE8
    hold_cyc = HLD_BASE << (hold_code - 4'h1); // RULE6
  end

  // peak comparisons refreshed on every converter sample
  always_ff @(posedge clock) begin
    if (srst || !loop_on) begin
      above_q <= 1'b0;
      below_q <= 1'b0;
      limit_q <= 1'b0;
      gate_on_q <= 1'b0;
    end else if (adc_valid) begin
      above_q <= level > rlc_pkg::TARGET_BASE
        + int'(ctrl_a_q[rlc_pkg::TARGET_LSB +: 4]); // RULE4 RULE2
      below_q <= level < rlc_pkg::TARGET_BASE
        + int'(ctrl_a_q[rlc_pkg::TARGET_LSB +: 4]); // RULE4
      limit_q <= peak > rlc_pkg::LIMIT_MAG; // RULE15
      gate_on_q <= gate_q[rlc_pkg::GATE_EN_BIT]
        && (level < gate_ref); // RULE16 RULE20
    end
  end

  // gain loop; the ceiling clamp wins over every ramp
  always_ff @(posedge clock) begin
    if (srst || !loop_on) begin
      state_q <= rlc_pkg::RLC_OFF;
      cnt_q <= '0;
      loop_gain_q <= left_applied_q; // loop starts from software gain
    end else if (loop_gain_q > ceiling) begin
      loop_gain_q <= ceiling; // RULE5
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        rlc_pkg::RLC_OFF: begin
          state_q <= rlc_pkg::RLC_DOWN;
          cnt_q <= '0;
        end
        rlc_pkg::RLC_DOWN: begin
          if (above_q || limit_q) begin // RULE7 RULE15
            if (freeze && !limit_q) begin
              cnt_q <= cnt_q;
            end else if (cnt_q >= down_cyc - 1) begin // RULE23
              cnt_q <= '0;
              if (loop_gain_q != '0) begin
                loop_gain_q <= loop_gain_q - 1'b1;
              end
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end else if (below_q) begin
            cnt_q <= '0;
            state_q <= (hold_code == 4'h0) ? rlc_pkg::RLC_UP
                                           : rlc_pkg::RLC_HOLD; // RULE6
          end
        end
        rlc_pkg::RLC_HOLD: begin
          if (!below_q) begin
            state_q <= rlc_pkg::RLC_DOWN; // RULE7
            cnt_q <= '0;
          // a hold code cleared while holding ends the wait at once
          end else if (hold_code == 4'h0
                       || cnt_q >= hold_cyc - 1) begin // RULE6
            state_q <= rlc_pkg::RLC_UP;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        rlc_pkg::RLC_UP: begin
          if (!below_q) begin
            state_q <= rlc_pkg::RLC_DOWN;
            cnt_q <= '0;
          end else if (freeze) begin
            cnt_q <= cnt_q; // RULE18
          end else if (cnt_q >= up_cyc - 1) begin // RULE23 RULE8
            cnt_q <= '0;
            if (loop_gain_q < ceiling) begin
              loop_gain_q <= loop_gain_q + 1'b1;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  // software gain path; writes to a loop-held channel are dropped
  always_ff @(posedge clock) begin
    if (srst) begin
      sw_left_q <= rlc_pkg::SW_GAIN_RST;
      sw_right_q <= rlc_pkg::SW_GAIN_RST;
      left_applied_q <= rlc_pkg::SW_GAIN_RST[rlc_pkg::GAIN_W-1:0];
      right_applied_q <= rlc_pkg::SW_GAIN_RST[rlc_pkg::GAIN_W-1:0];
    end else if (write_ok && idx == rlc_pkg::IDX_LEFT_GAIN && !loop_on) begin
      sw_left_q <= avs_writedata[rlc_pkg::REG_W-1:0]; // RULE1
      if (avs_writedata[rlc_pkg::SW_UPD_BIT]) begin
        left_applied_q <= avs_writedata[rlc_pkg::GAIN_W-1:0];
        right_applied_q <= sw_right_q[rlc_pkg::GAIN_W-1:0];
      end
    end else if (write_ok && idx == rlc_pkg::IDX_RIGHT_GAIN && !stereo) begin
      sw_right_q <= avs_writedata[rlc_pkg::REG_W-1:0]; // RULE1 RULE11
      if (avs_writedata[rlc_pkg::SW_UPD_BIT] && !loop_on) begin
        left_applied_q <= sw_left_q[rlc_pkg::GAIN_W-1:0];
        right_applied_q <= avs_writedata[rlc_pkg::GAIN_W-1:0];
      end else if (avs_writedata[rlc_pkg::SW_UPD_BIT]) begin
        right_applied_q <= avs_writedata[rlc_pkg::GAIN_W-1:0];
      end
    end
  end

  // loop configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_a_q <= rlc_pkg::CTRL_A_RST;
      ctrl_b_q <= rlc_pkg::CTRL_B_RST;
      ramp_q <= rlc_pkg::RAMP_RST;
      gate_q <= rlc_pkg::GATE_RST; // RULE19
    end else if (write_ok) begin
      if (idx == rlc_pkg::IDX_CTRL_A) begin
        ctrl_a_q <= avs_writedata[rlc_pkg::REG_W-1:0];
      end
      if (idx == rlc_pkg::IDX_CTRL_B) begin
        ctrl_b_q <= avs_writedata[rlc_pkg::REG_W-1:0];
      end
      if (idx == rlc_pkg::IDX_RAMP) begin
        ramp_q <= avs_writedata[rlc_pkg::REG_W-1:0];
      end
      if (idx == rlc_pkg::IDX_GATE) begin
        gate_q <= avs_writedata[rlc_pkg::REG_W-1:0];
      end
    end
  end

  // amplifier and converter controls, all registered
  always_ff @(posedge clock) begin
    if (srst) begin
      left_gain_q <= rlc_pkg::SW_GAIN_RST[rlc_pkg::GAIN_W-1:0];
      right_gain_q <= rlc_pkg::SW_GAIN_RST[rlc_pkg::GAIN_W-1:0];
      left_zc_q <= 1'b0;
      right_zc_q <= 1'b0;
      left_sil_q <= 1'b1;
      right_sil_q <= 1'b1;
      left_mute_q <= 1'b0;
      right_mute_q <= 1'b0;
    end else begin
      left_gain_q <= loop_on ? loop_gain_q : left_applied_q; // RULE2
      right_gain_q <= stereo ? loop_gain_q : right_applied_q; // RULE10
      left_zc_q <= loop_on ? ctrl_b_q[rlc_pkg::LOOP_ZC_BIT]
                           : sw_left_q[rlc_pkg::SW_ZC_BIT]; // RULE14
      right_zc_q <= stereo ? ctrl_b_q[rlc_pkg::LOOP_ZC_BIT]
                           : sw_right_q[rlc_pkg::SW_ZC_BIT]; // RULE14
      left_sil_q <= !loop_on && sw_left_q[rlc_pkg::SW_SIL_BIT]; // RULE1
      right_sil_q <= !stereo && sw_right_q[rlc_pkg::SW_SIL_BIT]; // RULE11
      left_mute_q <= gate_on_q && loop_on
        && gate_q[rlc_pkg::ACT_LSB +: 2] == rlc_pkg::GATE_MUTE; // RULE18
      right_mute_q <= gate_on_q && stereo
        && gate_q[rlc_pkg::ACT_LSB +: 2] == rlc_pkg::GATE_MUTE; // RULE20
    end
  end

  // bus slave: one wait cycle, then a single ready cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if ((avs_read || avs_write) && wait_q) begin
      wait_q <= 1'b0;
      rdata_q <= '0;
      if (read_ok && word_ok) begin
        unique case (idx)
          rlc_pkg::IDX_LEFT_GAIN: rdata_q <= 32'(sw_left_q);
          rlc_pkg::IDX_RIGHT_GAIN: rdata_q <= 32'(sw_right_q);
          rlc_pkg::IDX_CTRL_A: rdata_q <= 32'(ctrl_a_q);
          rlc_pkg::IDX_CTRL_B: rdata_q <= 32'(ctrl_b_q);
          rlc_pkg::IDX_RAMP: rdata_q <= 32'(ramp_q);
          rlc_pkg::IDX_GATE: rdata_q <= 32'(gate_q);
          rlc_pkg::IDX_STATUS: rdata_q <= 32'({gate_on_q, limit_q,
            above_q, below_q, state_q, loop_gain_q});
          default: rdata_q <= '0;
        endcase
      end
    end else begin
      wait_q <= 1'b1;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign left_input_gain = left_gain_q;
  assign right_input_gain = right_gain_q;
  assign left_zero_cross_enable = left_zc_q;
  assign right_zero_cross_enable = right_zc_q;
  assign left_input_silence = left_sil_q;
  assign right_input_silence = right_sil_q;
  assign adc_left_mute = left_mute_q;
  assign adc_right_mute = right_mute_q;

  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  sequence loop_held_s;
    loop_on ##1 loop_on;
  endsequence

  loop_silence_a: assert property (loop_held_s |-> !left_sil_q) // RULE1
    else $error("silence driven while loop holds left");
  loop_gain_a: assert property (loop_held_s // RULE2
    |=> left_gain_q == $past(loop_gain_q))
    else $error("left gain not taken from loop");
  ceil_hold_a: assert property (loop_on ##2 loop_on // RULE5
    |-> loop_gain_q <= ceiling)
    else $error("loop gain above ceiling");
  stereo_same_a: assert property (stereo ##1 stereo // RULE10
    |=> left_gain_q == right_gain_q)
    else $error("stereo gains differ");
  right_free_a: assert property (loop_on && !stereo // RULE11
    |=> right_gain_q == $past(right_applied_q))
    else $error("right gain not software value");
  down_step_a: assert property (state_q == rlc_pkg::RLC_HOLD // RULE7
    && !below_q && loop_on && loop_gain_q <= ceiling
    |=> state_q == rlc_pkg::RLC_DOWN)
    else $error("hold kept while level not below target");
  gate_loop_a: assert property (left_mute_q || right_mute_q |-> $past(loop_on)) // RULE20
    else $error("gate muted without loop");
  freeze_gain_a: assert property (freeze && !limit_q && loop_on // RULE18
    && state_q == rlc_pkg::RLC_UP && loop_gain_q <= ceiling
    |=> $stable(loop_gain_q))
    else $error("gain moved under freeze");
  bus_answer_a: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one ready cycle");
endmodule : rlc_top
`default_nettype wire

// File: verif/record_level_control_bench.sv
// Purpose: self-checking bench for the record level loop
// Assumes: shortened hold and decay counts through the parameters
// Notes: register contents kept in a small model array
`timescale 1ns/100ps
`default_nettype none
module record_level_control_bench;
  logic clock, srst, avs_read, avs_write, avs_waitrequest, adc_valid;
  logic left_excluded, right_excluded;
  logic [1:0] boost_code;
  logic [rlc_pkg::ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, seed_v;
  logic signed [15:0] adc_left, adc_right;
  logic [15:0] left_amp, right_amp;
  logic [5:0] left_input_gain, right_input_gain;
  logic left_zero_cross_enable, right_zero_cross_enable;
  logic left_input_silence, right_input_silence;
  logic adc_left_mute, adc_right_mute;
  logic [8:0] reg_model [0:31];
  int n_mismatch, checks;
  rlc_top #(.DECAY_STEP_CYC(8), .HOLD_BASE_CYC(16)) i_rlc_top (
    .clock(clock), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .adc_left(adc_left),
    .adc_right(adc_right), .adc_valid(adc_valid),
    .left_excluded(left_excluded), .right_excluded(right_excluded),
    .boost_code(boost_code), .left_input_gain(left_input_gain),
    .right_input_gain(right_input_gain),
    .left_zero_cross_enable(left_zero_cross_enable),
    .right_zero_cross_enable(right_zero_cross_enable),
    .left_input_silence(left_input_silence),
    .right_input_silence(right_input_silence),
    .adc_left_mute(adc_left_mute), .adc_right_mute(adc_right_mute));
  rlc_adc_model i_rlc_adc_model (.clock(clock), .srst(srst),
    .left_gain(left_input_gain), .right_gain(right_input_gain),
    .left_amp(left_amp), .right_amp(right_amp), .adc_left(adc_left),
    .adc_right(adc_right), .adc_valid(adc_valid));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: pin %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge clock);
    avs_address <= {idx[5:0], 2'b00};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : bus
  function automatic logic [8:0] fmask(input logic [7:0] idx);
    case (idx)
      8'h00, 8'h01: return 9'h0ff;
      8'h12: return 9'h08f;
      8'h13, 8'h14: return 9'h0ff;
      default: return 9'h1ff;
    endcase
  endfunction : fmask
  task automatic wr(input logic [7:0] idx, input logic [8:0] v);
    bus(1'b1, idx, {23'h0, v});
    // the left gain register is frozen while the loop owns it
    if (!(idx == 8'h00 && reg_model[17][8]) && idx < 8'h15)
      reg_model[idx[4:0]] = v;
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0);
    cmp_reg(rd & {23'h0, fmask(idx)}, {23'h0, reg_model[idx[4:0]] & fmask(idx)});
  endtask : rd_chk
  task automatic restart_loop(input logic [8:0] ctrl_a);
    wr(8'h11, 9'h03b);
    wr(8'h00, 9'h117);
    wr(8'h11, ctrl_a);
  endtask : restart_loop
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    left_excluded = 1'b0;
    right_excluded = 1'b0;
    boost_code = 2'h0;
    left_amp = 16'h0;
    right_amp = 16'h0;
    n_mismatch = 0;
    checks = 0;
    foreach (reg_model[i]) reg_model[i] = 9'h000;
    reg_model[0] = 9'h097;
    reg_model[1] = 9'h097;
    reg_model[17] = 9'h07b;
    reg_model[19] = 9'h032;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    seed_v = $urandom(29);
    // reset values and an unmapped index
    rd_chk(8'h11);
    rd_chk(8'h12);
    rd_chk(8'h13);
    rd_chk(8'h14);
    bus(1'b0, 8'h05, 32'h0);
    cmp_reg(rd, 32'h0);
    cmp_pin({2'h0, left_input_gain}, 8'h17);
    cmp_pin({6'h0, left_input_silence, right_input_silence}, 8'h3);
    $display("test reset done");
    repeat (4) begin
      wr(8'h13, 9'($urandom) & 9'h0ff);
      rd_chk(8'h13);
      wr(8'h12, 9'($urandom) & 9'h08f);
      rd_chk(8'h12);
    end
    $display("test readback done");
    // loud signal, slowest attack, longest hold: limiter must still cut
    wr(8'h12, 9'h00f);
    wr(8'h13, 9'h00a);
    wr(8'h00, 9'h117);
    wr(8'h11, 9'h17b);
    left_amp <= 16'h7fff;
    repeat (6000) @(posedge clock);
    cmp_pin({7'h0, left_input_gain < 6'h17 && left_input_gain > 6'h12}, 8'h1);
    wr(8'h00, 9'h13f);
    rd_chk(8'h00);
    wr(8'h01, 9'h120);
    repeat (4) @(posedge clock);
    cmp_pin({2'h0, right_input_gain}, 8'h20);
    cmp_pin({6'h0, left_input_silence, right_input_silence}, 8'h0);
    $display("test limiter done");
    // quiet signal: hold first, then ramp to the ceiling
    left_amp <= 16'h1 + 16'($urandom % 3);
    wr(8'h13, 9'h000);
    wr(8'h12, 9'h00a);
    restart_loop(9'h13b);
    repeat (2000) @(posedge clock);
    cmp_pin({2'h0, left_input_gain}, 8'h17);
    wr(8'h12, 9'h000);
    repeat (1500) @(posedge clock);
    cmp_pin({2'h0, left_input_gain}, 8'(63 - 8 * (7 - 3)));
    $display("test hold and ceiling done");
    wr(8'h14, 9'h0fb);
    repeat (200) @(posedge clock);
    cmp_pin({6'h0, adc_left_mute, adc_right_mute}, 8'h2);
    wr(8'h14, 9'h0f9);
    repeat (200) @(posedge clock);
    cmp_pin({6'h0, adc_left_mute, adc_right_mute}, 8'h0);
    // lowest threshold: only the boost term decides whether the gate cuts
    left_amp <= 16'h3;
    wr(8'h14, 9'h003);
    repeat (200) @(posedge clock);
    cmp_pin({6'h0, adc_left_mute, adc_right_mute}, 8'h0);
    boost_code <= 2'h3;
    repeat (200) @(posedge clock);
    cmp_pin({6'h0, adc_left_mute, adc_right_mute}, 8'h2);
    boost_code <= 2'h0;
    wr(8'h14, 9'h0fb);
    wr(8'h11, 9'h03b);
    repeat (200) @(posedge clock);
    cmp_pin({6'h0, adc_left_mute, adc_right_mute}, 8'h0);
    wr(8'h14, 9'h000);
    $display("test gate done");
    // stereo: loud right pulls both gains, then right is excluded
    right_amp <= 16'h7fff;
    left_amp <= 16'h2;
    restart_loop(9'h1fb);
    repeat (5000) @(posedge clock);
    cmp_pin({2'h0, left_input_gain}, {2'h0, right_input_gain});
    cmp_pin({7'h0, left_input_gain < 6'h17}, 8'h1);
    right_excluded <= 1'b1;
    repeat (3000) @(posedge clock);
    cmp_pin({2'h0, left_input_gain}, 8'h3f);
    wr(8'h12, 9'h080);
    repeat (20) @(posedge clock);
    cmp_pin({6'h0, left_zero_cross_enable, right_zero_cross_enable}, 8'h3);
    $display("test stereo and zero cross done");
    wrap_up();
  end
endmodule : record_level_control_bench
`default_nettype wire

// File: verif/rlc_adc_model.sv
// Purpose: stand-in for the input amplifiers and the two converters
// Assumes: one sample every four clocks, sign alternating each sample
// Notes: output doubles every eight gain codes and saturates
`timescale 1ns/100ps
`default_nettype none
module rlc_adc_model (
  input wire logic clock,
  input wire logic srst,
  input wire logic [rlc_pkg::GAIN_W-1:0] left_gain,
  input wire logic [rlc_pkg::GAIN_W-1:0] right_gain,
  input wire logic [15:0] left_amp,
  input wire logic [15:0] right_amp,
  output logic signed [rlc_pkg::SAMPLE_W-1:0] adc_left,
  output logic signed [rlc_pkg::SAMPLE_W-1:0] adc_right,
  output logic adc_valid
);
  logic [1:0] phase_q;
  logic sign_q;
  function automatic logic [15:0] amp_scale(input logic [15:0] amp,
                                            input logic [5:0] g);
    logic [31:0] v;
    v = 32'(amp) << g[5:3];
    return (v > 32'h7fff) ? 16'h7fff : v[15:0];
  endfunction : amp_scale
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_q <= 2'h0;
      sign_q <= 1'b0;
      adc_valid <= 1'b0;
      adc_left <= 16'h0;
      adc_right <= 16'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
      adc_valid <= (phase_q == 2'h3);
      if (phase_q == 2'h3) begin
        // alternating sign gives the zero-cross logic real crossings
        sign_q <= ~sign_q;
        adc_left <= sign_q ? 16'h0 - amp_scale(left_amp, left_gain) :
                    amp_scale(left_amp, left_gain);
        adc_right <= sign_q ? 16'h0 - amp_scale(right_amp, right_gain) :
                     amp_scale(right_amp, right_gain);
      end else begin
        // data outside the valid pulse is not worth holding
        adc_left <= ~adc_left;
        adc_right <= ~adc_right;
      end
    end
  end
endmodule : rlc_adc_model
`default_nettype wire
